//--- tx_ser_pkg.sv
// constants for the transmit parallel-to-serial path
package tx_ser_pkg;
  localparam int WORD_BITS            = 8;
  localparam int CLK_NS               = 20;
  // scaled parallel clock period for the higher rate (bench link clock)
  localparam int PCLK_HIGH_NS         = 160;
  localparam int PCLK_HIGH_CYC        = PCLK_HIGH_NS / CLK_NS;
  localparam int SER_RATE_HIGH_KBPS   = 622080;
  localparam int SER_RATE_LOW_KBPS    = 155520;
  localparam int RATE_RATIO           = SER_RATE_HIGH_KBPS / SER_RATE_LOW_KBPS;
  localparam int BIT_CYC_HIGH         = PCLK_HIGH_CYC / WORD_BITS;
  localparam int BIT_CYC_LOW          = BIT_CYC_HIGH * RATE_RATIO;
  localparam int HALF_BITS            = WORD_BITS / 2;
  localparam int CNT_W                = 8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic       DIR_RESET    = 1'b0;
endpackage

//--- sonet_tx_parallel_serializer.sv
// transmit parallel-word capture, two-entry buffer and msb-first serializer
`timescale 1ns/10ps
module sonet_tx_parallel_serializer #(
  parameter int BUF_W = tx_ser_pkg::WORD_BITS,
  parameter int BUF_D = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [BUF_W-1:0] tx_parallel_word_in,
  input  wire logic             tx_clock_direction_select,
  input  wire logic             tx_rate_high,
  input  wire logic             tx_parallel_clock_pin_in,
  output logic                  tx_parallel_clock_pin_out,
  output logic                  tx_parallel_clock_pin_oe_n,
  output logic                  tx_serial_out_pos,
  output logic                  tx_serial_out_neg,
  output logic                  tx_word_ready
);
  localparam int CW = tx_ser_pkg::CNT_W;

  initial begin
    if (BUF_W != tx_ser_pkg::WORD_BITS || BUF_D != 2) begin
      $error("buffer must be one word wide and two entries deep");
    end
  end

  // two-flop synchronisers plus one age stage for pins
  logic [BUF_W-1:0] data_s1_r, data_s2_r, data_s3_r;
  logic [2:0]       pin_r;
  logic [1:0]       dir_sy_r, rate_sy_r;
  logic             dir_r, rate_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_s1_r <= '0;
      data_s2_r <= '0;
      data_s3_r <= '0;
      pin_r     <= 3'h0;
      dir_sy_r  <= {2{tx_ser_pkg::DIR_RESET}};
      dir_r     <= tx_ser_pkg::DIR_RESET;
      rate_sy_r <= 2'h0;
      rate_r    <= 1'b0;
    end else begin
      data_s1_r <= tx_parallel_word_in;
      data_s2_r <= data_s1_r;
      data_s3_r <= data_s2_r;
      pin_r     <= {pin_r[1:0], tx_parallel_clock_pin_in};
      dir_sy_r  <= {dir_sy_r[0], tx_clock_direction_select};
      dir_r     <= dir_sy_r[1];
      rate_sy_r <= {rate_sy_r[0], tx_rate_high};
      rate_r    <= rate_sy_r[1];
    end
  end

  // configuration change restarts the timing
  logic cfg_chg;
  assign cfg_chg = (dir_r != dir_sy_r[1]) || (rate_r != rate_sy_r[1]);

  logic [CW-1:0] bit_cyc;
  assign bit_cyc = rate_r ? CW'(tx_ser_pkg::BIT_CYC_HIGH)
                          : CW'(tx_ser_pkg::BIT_CYC_LOW);

  // bit-period timer
  logic [CW-1:0] bit_cnt_r;
  logic          bit_tick;
  assign bit_tick = (bit_cnt_r == bit_cyc - CW'(1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r <= '0;
    end else if (cfg_chg || bit_tick) begin
      bit_cnt_r <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_r + CW'(1);
    end
  end

  // own parallel clock: half period is four bit periods
  logic       pclk_out_r;
  logic [2:0] half_cnt_r;
  logic       own_rise;
  assign own_rise = bit_tick && (half_cnt_r == 3'(tx_ser_pkg::HALF_BITS - 1)) && !pclk_out_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pclk_out_r <= 1'b0;
      half_cnt_r <= 3'h0;
    end else if (cfg_chg) begin
      pclk_out_r <= 1'b0;
      half_cnt_r <= 3'h0;
    end else if (bit_tick) begin
      if (half_cnt_r == 3'(tx_ser_pkg::HALF_BITS - 1)) begin
        half_cnt_r <= 3'h0;
        pclk_out_r <= !pclk_out_r;
      end else begin
        half_cnt_r <= half_cnt_r + 3'h1;
      end
    end
  end
  assign tx_parallel_clock_pin_out  = pclk_out_r;
  assign tx_parallel_clock_pin_oe_n = !dir_r;

  // capture on the rising edge of whichever clock times the bus
  logic ext_rise, capture;
  assign ext_rise = pin_r[1] && !pin_r[2];
  assign capture  = dir_r ? own_rise : ext_rise;

  // two-entry word buffer
  logic [BUF_W-1:0] buf_mem [BUF_D];
  logic             wp_r, rp_r;
  logic [1:0]       fill_r;
  logic             push, pop, buf_valid;
  assign tx_word_ready = (fill_r != 2'(BUF_D));
  assign buf_valid     = (fill_r != 2'h0);
  assign push          = capture && tx_word_ready;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      fill_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= !wp_r;
      end
      if (pop) begin
        rp_r <= !rp_r;
      end
      fill_r <= fill_r + 2'(push) - 2'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      buf_mem[wp_r] <= data_s3_r;
    end
  end

  // msb-first shifter
  logic [BUF_W-1:0] sh_r;
  logic [2:0]       left_r;
  logic             ser_r, load;
  logic [BUF_W-1:0] head_word;
  assign head_word = buf_mem[rp_r];
  assign load      = bit_tick && (left_r == 3'h0) && buf_valid;
  assign pop       = load;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r   <= '0;
      left_r <= 3'h0;
      ser_r  <= 1'b0;
    end else if (load) begin
      ser_r  <= head_word[BUF_W-1];
      sh_r   <= {head_word[BUF_W-2:0], 1'b0};
      left_r <= tx_ser_pkg::LAST_BIT_IDX;
    end else if (bit_tick) begin
      if (left_r != 3'h0) begin
        ser_r  <= sh_r[BUF_W-1];
        sh_r   <= {sh_r[BUF_W-2:0], 1'b0};
        left_r <= left_r - 3'h1;
      end else begin
        ser_r <= 1'b0; // underrun idles low
      end
    end
  end
  assign tx_serial_out_pos = ser_r;
  assign tx_serial_out_neg = !ser_r;

  // checks
  // the checks below watch the timing chain, the buffer and the shifter
  // lsb of the head word, kept as a plain net for the past-value check
  logic head_lsb;
  assign head_lsb = head_word[0];

  // pin direction and the driven parallel clock

  chk_oe_follows_dir: assert property (@(posedge clk) disable iff (!arst_n)
    tx_parallel_clock_pin_oe_n == !dir_r) else $error("clock pin enable wrong");
  chk_pclk_period_hi: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    ($rose(pclk_out_r) && rate_r) |-> ##8 $rose(pclk_out_r))
    else $error("parallel clock period wrong");
  chk_pclk_period_lo: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    ($rose(pclk_out_r) && !rate_r) |-> ##32 $rose(pclk_out_r))
    else $error("low rate parallel clock period wrong");
  chk_pin_released: assert property (@(posedge clk) disable iff (!arst_n)
    !dir_r |-> tx_parallel_clock_pin_oe_n) else $error("clock pin driven in input mode");

  // bit order and bit rate on the serial pair
  chk_msb_first: assert property (@(posedge clk) disable iff (!arst_n)
    load |=> (ser_r == $past(head_word[BUF_W-1]))) else $error("msb not first");
  chk_lsb_last: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    (load && rate_r) |-> ##8 (ser_r == $past(head_lsb, 8))) else $error("lsb not last");
  chk_diff_pair: assert property (@(posedge clk) disable iff (!arst_n)
    tx_serial_out_neg != tx_serial_out_pos) else $error("outputs not complementary");
  chk_low_bit_rate: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    (bit_tick && !rate_r) |=> !bit_tick [*3] ##1 bit_tick) else $error("low bit rate wrong");
  chk_idle_low: assert property (@(posedge clk) disable iff (!arst_n)
    (bit_tick && (left_r == 3'h0) && !buf_valid) |=> !tx_serial_out_pos)
    else $error("underrun not idling low");

  // one word per parallel clock period at the high rate; at the low rate no reload within eight cycles
  chk_one_load_word: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    (load && rate_r) |=> !load [*7]) else $error("word reloaded early");
  chk_one_load_low: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    (load && !rate_r) |=> !load [*8]) else $error("low rate word reloaded early");

  // capture only at a rising edge of the clock that times the bus
  chk_latch_rising: assert property (@(posedge clk) disable iff (!arst_n)
    (push && !dir_r) |=> (pin_r[2] && !$past(pin_r[2]))) else $error("latch off edge");
  chk_latch_own: assert property (@(posedge clk) disable iff (!arst_n || cfg_chg)
    (push && dir_r) |=> $rose(pclk_out_r)) else $error("latch off own clock edge");

  // buffer fill never passes its depth
  chk_no_overrun: assert property (@(posedge clk) disable iff (!arst_n)
    fill_r <= 2'(BUF_D)) else $error("buffer overrun");

  // main scenarios: both rates, both directions, full buffer
  cov_load_high: cover property (@(posedge clk) disable iff (!arst_n) load && rate_r);
  cov_load_low: cover property (@(posedge clk) disable iff (!arst_n) load && !rate_r);
  cov_ext_capture: cover property (@(posedge clk) disable iff (!arst_n) push && !dir_r);
  cov_buf_full: cover property (@(posedge clk) disable iff (!arst_n) !tx_word_ready);
  cov_own_capture: cover property (@(posedge clk) disable iff (!arst_n) push && dir_r);
endmodule

//--- framer_model.sv
// framer-side model: parallel clock source and word launcher
`timescale 1ns/10ps
module framer_model (
  input  wire logic       run,
  input  wire logic       drive_clk,
  input  wire logic       dev_clk,
  output logic            pclk,
  output logic            pclk_en,
  output logic [7:0]      word
);
  logic [7:0] words_q[$];
  logic       launch;
  int         half_ns = 80;
  // own clock, stands still outside frames
  initial begin
    pclk = 1'b0;
    word = 8'h00;
    #37;
    forever begin
      #(half_ns);
      pclk = (run && drive_clk) ? ~pclk : 1'b0;
    end
  end
  assign pclk_en = drive_clk;
  assign launch = drive_clk ? pclk : dev_clk;
  // next word launched on the rising edge of the reference clock
  always @(posedge launch) begin
    word <= (words_q.size() > 0) ? words_q.pop_front() : 8'h00;
  end
endmodule

//--- sonet_tx_parallel_serializer_tb.sv
// self-checking bench for the transmit serializer with a framer model
`timescale 1ns/10ps
module sonet_tx_parallel_serializer_tb;
  logic       clk, arst_n, dir, rate_high, pin, pin_out, oe_n, pos, neg, ready;
  logic       run, fr_clk, fr_en;
  logic [7:0] word;
  int         fail_count, comparisons;
  // wire level of the two-way clock pin
  assign pin = !oe_n ? pin_out : (fr_en ? fr_clk : 1'b0);
  initial clk = 1'b0;
  always #10 clk = ~clk;
  sonet_tx_parallel_serializer i_sonet_tx_parallel_serializer (
    .clk(clk), .arst_n(arst_n), .tx_parallel_word_in(word),
    .tx_clock_direction_select(dir), .tx_rate_high(rate_high),
    .tx_parallel_clock_pin_in(pin), .tx_parallel_clock_pin_out(pin_out),
    .tx_parallel_clock_pin_oe_n(oe_n), .tx_serial_out_pos(pos),
    .tx_serial_out_neg(neg), .tx_word_ready(ready));
  framer_model i_framer_model (.run(run), .drive_clk(!dir), .dev_clk(pin_out),
    .pclk(fr_clk), .pclk_en(fr_en), .word(word));
  // compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // queue words at the framer, then rebuild them from the serial line
  task automatic send(input logic [7:0] w[$], input int bit_cyc);
    logic [7:0] got;
    got = 8'h00;
    foreach (w[i]) i_framer_model.words_q.push_back(w[i]);
    run = 1'b1;
    for (int n = 0; n < 400 && pos !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    foreach (w[i]) begin
      for (int b = 0; b < 8; b++) begin
        got = {got[6:0], pos};
        check("neg", {7'h00, neg}, {7'h00, ~pos});
        repeat (bit_cyc) @(posedge clk);
        #1;
      end
      check("word", got, w[i]);
    end
    run = 1'b0;
  endtask
  // cycles between two rises of the driven parallel clock
  task automatic pclk_period(input int exp);
    int t0, n;
    logic prev;
    t0 = -1;
    prev = 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (pin_out && !prev && t0 >= 0) break;
      if (pin_out && !prev) t0 = n;
      prev = pin_out;
    end
    check("pclk_period", 8'(n - t0), 8'(exp));
  endtask
  // main sequence
  initial begin
    arst_n = 1'b0;
    dir = 1'b0;
    rate_high = 1'b1;
    run = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check("oe_n", {7'h00, oe_n}, 8'h01);
    check("ready", {7'h00, ready}, 8'h01);
    repeat (6) @(posedge clk);
    send('{8'hA5, 8'h3C, 8'h0F, 8'h81}, 1);
    check("oe_n", {7'h00, oe_n}, 8'h01);
    @(posedge clk);
    dir <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    check("oe_n", {7'h00, oe_n}, 8'h00);
    pclk_period(8);
    send('{8'hC3, 8'h5A, 8'hE7}, 1);
    @(posedge clk);
    rate_high <= 1'b0;
    dir <= 1'b0;
    i_framer_model.half_ns = 320;
    repeat (40) @(posedge clk);
    send('{8'h9E, 8'h42}, 4);
    @(posedge clk);
    dir <= 1'b1;
    repeat (80) @(posedge clk);
    pclk_period(32);
    summarize();
  end
  // watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
